// ==== src/sfcp_consts.svh ====
// Constants for the serial memory command and protection front end
`ifndef SFCP_CONSTS_SVH
`define SFCP_CONSTS_SVH

`define SFCP_OP_SET_WE     8'h06
`define SFCP_OP_CLR_WE     8'h04
`define SFCP_OP_STAT_RD    8'h05
`define SFCP_OP_STAT_WR    8'h01
`define SFCP_OP_MEM_RD     8'h03
`define SFCP_OP_MEM_WR     8'h02
`define SFCP_OP_MEM_MASK   8'hF7
`define SFCP_OP_ADDR_MSB   3

`define SFCP_ST_WEL        1
`define SFCP_ST_BP_LO      2
`define SFCP_ST_BP_HI      3
`define SFCP_ST_ZERO_HI    4'h0
`define SFCP_ST_ZERO_LO    1'b0

`define SFCP_BP_NONE       2'h0
`define SFCP_BP_QUARTER    2'h1
`define SFCP_BP_HALF       2'h2
`define SFCP_BP_ALL        2'h3
`define SFCP_BP_RESET      2'h0
`define SFCP_PROT_QUARTER  9'h180
`define SFCP_PROT_HALF     9'h100

`define SFCP_ADDR_LAST     9'h1FF
`define SFCP_ADDR_FIRST    9'h000
`define SFCP_ADDR_STEP     9'h001
`define SFCP_BIT_LAST      3'h7
`define SFCP_BIT_FIRST     3'h0
`define SFCP_BIT_STEP      3'h1
`define SFCP_PINS_IDLE     5'h11

`endif

// ==== src/sfcp_pkg.sv ====
// Types shared by the serial memory command and protection front end
package sfcp_pkg;

	typedef enum logic [2:0] {
		SFCP_CMD   = 3'b000,
		SFCP_ADDR  = 3'b001,
		SFCP_WDATA = 3'b010,
		SFCP_RDATA = 3'b011,
		SFCP_SRD   = 3'b100,
		SFCP_SWR   = 3'b101,
		SFCP_SKIP  = 3'b110
	} sfcp_state_t;

	typedef struct packed {
		logic csN;
		logic sck;
		logic si;
		logic wpN;
		logic holdN;
	} sfcp_pins_t;

endpackage

// ==== src/sfcp_sync.sv ====
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module sfcp_sync #(
	parameter int              WIDTH   = 5,
	parameter int              STAGES  = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Pins and their synchronised copy
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] stage_r [STAGES-1];

	if (STAGES < 2) begin : g_check
		$error("sfcp_sync needs at least two stages");
	end

	// Only the next stage reads the first one
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < STAGES - 1; i++) begin
				stage_r[i] <= RST_VAL;
			end
			q <= RST_VAL;
		end else begin
			stage_r[0] <= d;
			for (int i = 1; i < STAGES - 1; i++) begin
				stage_r[i] <= stage_r[i-1];
			end
			q <= stage_r[STAGES-2];
		end
	end

endmodule

`default_nettype wire

// ==== src/sfcp_top.sv ====
// Serial memory slave: command decode, write latch, status and protection
`timescale 1ns/1ps
`default_nettype none
`include "sfcp_consts.svh"

// Notes on behaviour
// [RL1] Only clock modes 0 and 3; idle clock level sampled at each select fall.
// [RL2] First command bit taken on first rising clock after select goes low.
// [RL3] Master drops an idle-high clock before the first bit.
// [RL4] First byte after select is the command; address and data follow.
// [RL5] One command per select; master deselects between commands.
// [RL6] All transfers are 8-bit groups, most significant bit first.
// [RL7] Input sampled on rising clock; output changes only on falling clock.
// [RL8] Command 06h sets the write enable latch.
// [RL9] Command 04h clears the write enable latch.
// [RL10] Command 05h returns exactly one status byte.
// [RL11] Command 01h takes the next byte as new status, if allowed.
// [RL12] Master sets the latch earlier and holds write protect high first.
// [RL13] Memory read 0000A011b and write 0000A010b; A is address bit 8.
// [RL14] Latch is cleared at power-up.
// [RL15] Finishing any write clears the latch.
// [RL16] Status bit 1 shows the latch; status writes leave it alone.
// [RL17] Status bits 0 and 7-4 read zero and never change.
// [RL18] Block protect bits 3:2 are writable and kept across power cycles.
// [RL19] Code 00 none, 01 180h-1FFh, 10 100h-1FFh, 11 whole array.
// [RL20] Write protect pin low blocks every write.
// [RL21] Writes need latch set and pin high; protected blocks never written.
// [RL22] Select high: standby, inputs ignored, output released.
// [RL23] Pause pin low: operation frozen, clock and select ignored.
// [RL24] Sequential address increments per byte, wrapping 1FFh to 000h.
// [RL25] Unknown command is ignored until select is released.
module sfcp_top #(
	parameter int ADDR_W = 9
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Serial bus pins
	input  wire logic csN,
	input  wire logic sck,
	input  wire logic si,
	output logic      soOut,
	output logic      soOe,
	// Protection and pause pins
	input  wire logic wpN,
	input  wire logic holdN
);

	sfcp_pkg::sfcp_pins_t  pinRaw;
	sfcp_pkg::sfcp_pins_t  pinS;
	sfcp_pkg::sfcp_state_t state_r;
	logic [2:0]            cnt_r;
	logic [7:0]            shIn_r;
	logic [7:0]            outSh_r;
	logic [ADDR_W-1:0]     addr_r;
	logic                  isRead_r;
	logic                  wrDone_r;
	logic                  wel_r;
	logic [1:0]            bp_r = `SFCP_BP_RESET;
	logic [7:0]            mem [2**ADDR_W];
	logic                  csAct_r;
	logic                  sckPrev_r;
	logic                  mode3_r;
	logic                  seenRise_r;
	logic                  drvOn_r;
	logic                  holdOn;
	logic                  csFall;
	logic                  csRise;
	logic                  riseEdge;
	logic                  fallAct;
	logic                  byteDone;
	logic [7:0]            byteIn;
	logic                  cmdDone;
	logic                  opSetWe;
	logic                  opClrWe;
	logic                  memWe;
	logic                  srWe;
	logic [7:0]            statusByte;

	if (ADDR_W != 9) begin : g_check
		$error("sfcp_top protection map needs a 9-bit address");
	end

	function automatic logic isProt(input logic [8:0] a, input logic [1:0] bp);
		unique case (bp)                                            // see [RL19]
			`SFCP_BP_NONE:    isProt = 1'b0;
			`SFCP_BP_QUARTER: isProt = (a >= `SFCP_PROT_QUARTER);
			`SFCP_BP_HALF:    isProt = (a >= `SFCP_PROT_HALF);
			`SFCP_BP_ALL:     isProt = 1'b1;
		endcase
	endfunction

	function automatic logic [8:0] nextAddr(input logic [8:0] a);
		nextAddr = (a == `SFCP_ADDR_LAST) ? `SFCP_ADDR_FIRST
		                                  : 9'(a + `SFCP_ADDR_STEP);
	endfunction

	function automatic logic [7:0] statusOf(input logic [1:0] bp, input logic w);
		statusOf = {`SFCP_ST_ZERO_HI, bp, w, `SFCP_ST_ZERO_LO};
	endfunction

	assign pinRaw = '{csN: csN, sck: sck, si: si, wpN: wpN, holdN: holdN};

	sfcp_sync #(
		.WIDTH   (5),
		.STAGES  (2),
		.RST_VAL (`SFCP_PINS_IDLE)
	) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.d       (pinRaw),
		.q       (pinS)
	);

	// Edge finding on the synchronised pins
	assign holdOn   = pinS.holdN;                                 // see [RL23]
	assign csFall   = holdOn && !csAct_r && !pinS.csN;
	assign csRise   = holdOn && csAct_r && pinS.csN;
	assign riseEdge = holdOn && csAct_r && !pinS.csN                // see [RL22]
	                  && !sckPrev_r && pinS.sck;                   // see [RL7]
	assign fallAct  = holdOn && csAct_r && !pinS.csN && sckPrev_r && !pinS.sck
	                  && (seenRise_r || !mode3_r);                 // see [RL2]
	assign byteIn   = {shIn_r[6:0], pinS.si};                      // see [RL6]
	assign byteDone = riseEdge && (cnt_r == `SFCP_BIT_LAST);
	assign cmdDone  = byteDone && (state_r == sfcp_pkg::SFCP_CMD);  // see [RL4]
	assign opSetWe  = cmdDone && (byteIn == `SFCP_OP_SET_WE);       // see [RL8]
	assign opClrWe  = cmdDone && (byteIn == `SFCP_OP_CLR_WE);       // see [RL9]
	assign memWe    = byteDone && (state_r == sfcp_pkg::SFCP_WDATA)
	                  && wel_r && pinS.wpN                          // see [RL20]
	                  && !isProt(addr_r, bp_r);                     // see [RL21]
	assign srWe     = byteDone && (state_r == sfcp_pkg::SFCP_SWR)
	                  && wel_r && pinS.wpN;                         // see [RL21]
	assign statusByte = statusOf(bp_r, wel_r);              // see [RL16] [RL17]

	// Select tracking and clock mode capture
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			csAct_r    <= 1'b0;
			sckPrev_r  <= 1'b0;
			mode3_r    <= 1'b0;
			seenRise_r <= 1'b0;
		end else begin
			sckPrev_r <= pinS.sck;
			if (holdOn) begin
				csAct_r <= !pinS.csN;
			end
			if (csFall) begin
				mode3_r    <= pinS.sck;                             // see [RL1]
				seenRise_r <= 1'b0;
			end else if (riseEdge) begin
				seenRise_r <= 1'b1;
			end
		end
	end

	// Command sequencer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r  <= sfcp_pkg::SFCP_CMD;
			cnt_r    <= `SFCP_BIT_FIRST;
			shIn_r   <= '0;
			outSh_r  <= '0;
			addr_r   <= `SFCP_ADDR_FIRST;
			isRead_r <= 1'b0;
			wrDone_r <= 1'b0;
		end else if (csFall) begin
			state_r  <= sfcp_pkg::SFCP_CMD;                         // see [RL5]
			cnt_r    <= `SFCP_BIT_FIRST;
			wrDone_r <= 1'b0;
		end else if (riseEdge) begin
			cnt_r  <= cnt_r + `SFCP_BIT_STEP;
			shIn_r <= byteIn;
			if (cnt_r == `SFCP_BIT_LAST) begin
				unique case (state_r)
					sfcp_pkg::SFCP_CMD: begin
						if (byteIn == `SFCP_OP_STAT_RD) begin
							outSh_r <= statusByte;                   // see [RL10]
							state_r <= sfcp_pkg::SFCP_SRD;
						end else if (byteIn == `SFCP_OP_STAT_WR) begin
							state_r <= sfcp_pkg::SFCP_SWR;           // see [RL11]
						end else if ((byteIn & `SFCP_OP_MEM_MASK)
						             == `SFCP_OP_MEM_RD) begin       // see [RL13]
							addr_r[8] <= byteIn[`SFCP_OP_ADDR_MSB];
							isRead_r  <= 1'b1;
							state_r   <= sfcp_pkg::SFCP_ADDR;
						end else if ((byteIn & `SFCP_OP_MEM_MASK)
						             == `SFCP_OP_MEM_WR) begin       // see [RL13]
							addr_r[8] <= byteIn[`SFCP_OP_ADDR_MSB];
							isRead_r  <= 1'b0;
							state_r   <= sfcp_pkg::SFCP_ADDR;
						end else begin
							state_r <= sfcp_pkg::SFCP_SKIP;          // see [RL25]
						end
					end
					sfcp_pkg::SFCP_ADDR: begin
						if (isRead_r) begin
							outSh_r <= mem[{addr_r[8], byteIn}];
							addr_r  <= nextAddr({addr_r[8], byteIn});
							state_r <= sfcp_pkg::SFCP_RDATA;
						end else begin
							addr_r  <= {addr_r[8], byteIn};
							state_r <= sfcp_pkg::SFCP_WDATA;
						end
					end
					sfcp_pkg::SFCP_WDATA: begin
						addr_r   <= nextAddr(addr_r);                // see [RL24]
						wrDone_r <= 1'b1;
					end
					sfcp_pkg::SFCP_RDATA: begin
						outSh_r <= mem[addr_r];
						addr_r  <= nextAddr(addr_r);                 // see [RL24]
					end
					sfcp_pkg::SFCP_SRD: begin
						state_r <= sfcp_pkg::SFCP_SKIP;              // see [RL10]
					end
					sfcp_pkg::SFCP_SWR: begin
						wrDone_r <= 1'b1;
						state_r  <= sfcp_pkg::SFCP_SKIP;
					end
					default: begin
						state_r <= sfcp_pkg::SFCP_SKIP;
					end
				endcase
			end
		end else if (fallAct) begin
			outSh_r <= {outSh_r[6:0], 1'b0};                        // see [RL6]
		end
	end

	// Write enable latch
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wel_r <= 1'b0;                                          // see [RL14]
		end else if (opSetWe) begin
			wel_r <= 1'b1;                                          // see [RL8]
		end else if (opClrWe) begin
			wel_r <= 1'b0;                                          // see [RL9]
		end else if (csRise && wrDone_r) begin
			wel_r <= 1'b0;                                          // see [RL15]
		end
	end

	// Nonvolatile block protect bits keep their value through rst
	always_ff @(posedge sys_clk) begin
		if (srWe) begin
			bp_r <= byteIn[`SFCP_ST_BP_HI:`SFCP_ST_BP_LO];          // see [RL18]
		end
	end

	// Array storage, written the cycle each data byte completes
	always_ff @(posedge sys_clk) begin
		if (memWe) begin
			mem[addr_r] <= byteIn;                                  // see [RL21]
		end
	end

	// Serial output, updated on falling clock only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			drvOn_r <= 1'b0;
			soOut   <= 1'b0;
			soOe    <= 1'b0;
		end else begin
			if (!csAct_r || pinS.csN) begin
				drvOn_r <= 1'b0;                                    // see [RL22]
			end else if (fallAct) begin
				drvOn_r <= (state_r == sfcp_pkg::SFCP_RDATA)
				           || (state_r == sfcp_pkg::SFCP_SRD);
				soOut   <= outSh_r[7];                              // see [RL7]
			end
			soOe <= drvOn_r && holdOn && csAct_r && !pinS.csN;      // see [RL23]
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_setCmd;
		opSetWe;
	endsequence

	sequence s_writeEnd;
		csRise && wrDone_r && !opSetWe;
	endsequence

	a_wel_set: // see [RL8]
		assert property (s_setCmd |=> wel_r && statusByte[`SFCP_ST_WEL])
		else $error("latch not set by set command");
	a_wel_clear: // see [RL9]
		assert property (opClrWe |=> !wel_r)
		else $error("latch not cleared by clear command");
	a_wel_write_end: // see [RL15]
		assert property (s_writeEnd |=> !wel_r)
		else $error("latch survived a finished write");
	a_status_fixed: // see [RL17]
		assert property (statusByte[7:4] == 4'h0 && !statusByte[0])
		else $error("fixed status bits not zero");
	a_wp_blocks: // see [RL20]
		assert property ((memWe || srWe) |-> pinS.wpN && wel_r)
		else $error("write while protected");

	a_block_prot: // see [RL19]
		assert property (memWe |-> !(bp_r == `SFCP_BP_ALL)
		                 && !(bp_r == `SFCP_BP_HALF && addr_r[8])
		                 && !(bp_r == `SFCP_BP_QUARTER && addr_r[8:7] == 2'h3))
		else $error("write into protected block");

	a_bp_change: // see [RL11]
		assert property (!$stable(bp_r) |-> $past(srWe))
		else $error("protect bits changed without status write");

	a_addr_wrap: // see [RL24]
		assert property (memWe && addr_r == `SFCP_ADDR_LAST
		                 |=> addr_r == `SFCP_ADDR_FIRST)
		else $error("address did not wrap");

	a_out_fall: // see [RL7]
		assert property (!$stable(soOut) |-> $past(fallAct))
		else $error("output moved off a falling clock");

	a_out_standby: // see [RL22]
		assert property (pinS.csN || !holdOn |=> !soOe)
		else $error("output driven in standby or pause");

	a_stat_load: // see [RL10]
		assert property (cmdDone && byteIn == `SFCP_OP_STAT_RD
		                 |=> outSh_r == $past(statusByte)
		                 && state_r == sfcp_pkg::SFCP_SRD)
		else $error("status byte not loaded");

	a_unknown_skip: // see [RL25]
		assert property (state_r == sfcp_pkg::SFCP_SKIP && !csFall
		                 |=> state_r == sfcp_pkg::SFCP_SKIP && !memWe)
		else $error("ignored command left skip state");

endmodule

`default_nettype wire

// ==== verification/sfcp_host_model.sv ====
// Host-side serial bus master model for the memory front end
`timescale 1ns/1ps
`default_nettype none

module sfcp_host_model (
	// System clock used to pace the serial clock
	input  wire logic sys_clk,
	// Serial bus
	input  wire logic soOut,
	input  wire logic soOe,
	output var  logic csN,
	output var  logic sck,
	output var  logic si
);
	initial begin
		csN = 1'h1;
		sck = 1'h0;
		si  = 1'h0;
	end

	// Half of a 160 ns serial clock period, launched just after an edge
	task automatic half();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	// One select cycle of n bytes; mode 3 idles the clock high
	task automatic frame(input logic m3, input int n,
			input logic [7:0] tx [8], output logic [7:0] rx [8],
			output logic oe [8]);
		@(posedge sys_clk);
		#1;
		sck = m3;
		csN = 1'h0;
		half();
		sck = 1'h0;
		for (int b = 0; b < n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				si = tx[b][i];
				half();
				// A released output reads as the inverse of its last level
				rx[b][i] = soOe ? soOut : ~soOut;
				if (i == 6) begin
					oe[b] = soOe;
				end
				sck = 1'h1;
				half();
				sck = m3 & (b == n - 1) & (i == 0);
			end
		end
		half();
		csN = 1'h1;
		// Released data line shows a changing level, not the last bit
		si = ~si;
		half();
	endtask
endmodule

`default_nettype wire

// ==== verification/tb_spi_fram_command_and_protect.sv ====
// Self-checking bench for the serial memory command and protection block
`timescale 1ns/1ps
`default_nettype none
`include "sfcp_consts.svh"

module tb_spi_fram_command_and_protect;
	typedef struct packed {
		logic [1:0] bp;
		logic       we;
		logic       wp;
		logic [8:0] addr;
		logic [7:0] data;
		logic       ok;
	} sfcp_row_t;

	logic       sys_clk;
	logic       rst;
	logic       csN;
	logic       sck;
	logic       si;
	logic       soOut;
	logic       soOe;
	logic       wpN;
	logic       holdN;
	int         fails;
	int         n_tests;
	logic [7:0] tx [8];
	logic [7:0] rx [8];
	logic       oe [8];
	sfcp_row_t  r;
	sfcp_row_t  rows [10] = '{
		'{2'h0, 1'h1, 1'h1, 9'h1FF, 8'hA5, 1'h1},
		'{2'h1, 1'h1, 1'h1, 9'h17F, 8'h5A, 1'h1},
		'{2'h1, 1'h1, 1'h1, 9'h180, 8'hC3, 1'h0},
		'{2'h1, 1'h1, 1'h1, 9'h1FF, 8'h3C, 1'h0},
		'{2'h2, 1'h1, 1'h1, 9'h0FF, 8'h96, 1'h1},
		'{2'h2, 1'h1, 1'h1, 9'h100, 8'h69, 1'h0},
		'{2'h2, 1'h1, 1'h1, 9'h17F, 8'h0F, 1'h0},
		'{2'h3, 1'h1, 1'h1, 9'h000, 8'hF0, 1'h0},
		'{2'h0, 1'h0, 1'h1, 9'h055, 8'h81, 1'h0},
		'{2'h0, 1'h1, 1'h0, 9'h0AA, 8'h7E, 1'h0}
	};

	sfcp_top #(.ADDR_W(9)) dut (
		.sys_clk(sys_clk),
		.rst    (rst),
		.csN    (csN),
		.sck    (sck),
		.si     (si),
		.soOut  (soOut),
		.soOe   (soOe),
		.wpN    (wpN),
		.holdN  (holdN)
	);

	sfcp_host_model host (
		.sys_clk(sys_clk),
		.soOut  (soOut),
		.soOe   (soOe),
		.csN    (csN),
		.sck    (sck),
		.si     (si)
	);

	initial begin
		sys_clk = 1'h0;
	end

	always #10 sys_clk = ~sys_clk;

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: byte %h not %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: enable %b not %b", $time, got, exp);
		end
	endtask

	task automatic op(input logic [7:0] c);
		tx[0] = c;
		host.frame(1'h0, 1, tx, rx, oe);
	endtask

	// Status read with one spare byte to see the output let go
	task automatic status_read_cmd(input logic [7:0] exp);
		tx[0] = `SFCP_OP_STAT_RD;
		host.frame(1'h0, 3, tx, rx, oe);
		chk1(oe[0], 1'h0);
		chk1(oe[1], 1'h1);
		chk1(oe[2], 1'h0);
		chk8(rx[1], exp);
	endtask

	task automatic status_write_cmd(input logic [7:0] v);
		tx[0] = `SFCP_OP_STAT_WR;
		tx[1] = v;
		host.frame(1'h0, 2, tx, rx, oe);
	endtask

	task automatic setbp(input logic [1:0] bp);
		op(`SFCP_OP_SET_WE);
		status_write_cmd({4'h0, bp, 2'h0});
	endtask

	task automatic mem(input logic [7:0] base, input logic [8:0] a,
			input int n);
		tx[0] = base | {4'h0, a[8], 3'h0};
		tx[1] = a[7:0];
		host.frame(1'h0, n, tx, rx, oe);
	endtask

	task automatic pulse_rst();
		rst = 1'h1;
		repeat (3) @(posedge sys_clk);
		#1;
		rst = 1'h0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		fails++;
		$display("mismatch at %0t: run did not finish", $time);
		test_done();
	end

	initial begin
		fails = 0;
		n_tests = 0;
		wpN = 1'h1;
		holdN = 1'h1;
		pulse_rst();
		chk1(soOe, 1'h0);
		status_read_cmd(8'h00);
		foreach (rows[k]) begin
			r = rows[k];
			setbp(2'h0);
			op(`SFCP_OP_SET_WE);
			tx[2] = ~r.data;
			mem(`SFCP_OP_MEM_WR, r.addr, 3);
			setbp(r.bp);
			status_read_cmd({4'h0, r.bp, 2'h0});
			if (r.we) begin
				op(`SFCP_OP_SET_WE);
			end
			wpN = r.wp;
			tx[2] = r.data;
			mem(`SFCP_OP_MEM_WR, r.addr, 3);
			wpN = 1'h1;
			status_read_cmd({4'h0, r.bp, 2'h0});
			mem(`SFCP_OP_MEM_RD, r.addr, 3);
			chk8(rx[2], r.ok ? r.data : ~r.data);
		end
		// Latch set and clear, then an unknown code swallowing a set
		op(`SFCP_OP_SET_WE);
		status_read_cmd(8'h02);
		op(`SFCP_OP_CLR_WE);
		status_read_cmd(8'h00);
		tx[0] = 8'h16;
		tx[1] = `SFCP_OP_SET_WE;
		host.frame(1'h0, 2, tx, rx, oe);
		status_read_cmd(8'h00);
		// Clock idling high
		tx[0] = `SFCP_OP_SET_WE;
		host.frame(1'h1, 1, tx, rx, oe);
		tx[0] = `SFCP_OP_STAT_RD;
		host.frame(1'h1, 2, tx, rx, oe);
		chk8(rx[1], 8'h02);
		// Fixed bits and the latch bit ignore a status write
		status_write_cmd(8'hFF);
		status_read_cmd(8'h0C);
		op(`SFCP_OP_SET_WE);
		wpN = 1'h0;
		status_write_cmd(8'h00);
		wpN = 1'h1;
		status_read_cmd(8'h0C);
		status_write_cmd(8'h00);
		status_read_cmd(8'h0C);
		// Reset clears the latch but keeps the protect bits
		op(`SFCP_OP_SET_WE);
		pulse_rst();
		status_read_cmd(8'h0C);
		// Paused device ignores a whole select cycle
		holdN = 1'h0;
		op(`SFCP_OP_SET_WE);
		holdN = 1'h1;
		status_read_cmd(8'h0C);
		// Sequential write and read across the top address
		setbp(2'h0);
		op(`SFCP_OP_SET_WE);
		tx[2] = 8'h3C;
		tx[3] = 8'hC3;
		mem(`SFCP_OP_MEM_WR, 9'h1FF, 4);
		mem(`SFCP_OP_MEM_RD, 9'h1FF, 4);
		chk8(rx[2], 8'h3C);
		chk8(rx[3], 8'hC3);
		test_done();
	end
endmodule

`default_nettype wire
